// ==== verilog/ctimer_pkg.sv ====
// constants, register map and types for the compact timer
package ctimer_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO  = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI  = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_FLAGS   = 3'h6;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int POS_PAUSE  = 7;
  localparam int POS_CKSEL  = 4;
  localparam int POS_ON     = 3;
  localparam int POS_PERIOD = 0;
  localparam int POS_MODE   = 6;
  localparam int POS_OFUNC  = 4;
  localparam int POS_INIT   = 3;
  localparam int POS_INV    = 2;
  localparam int POS_SWAP   = 1;
  localparam int POS_CCLR   = 0;
  localparam int POS_FLAG_A = 0;
  localparam int POS_FLAG_P = 1;
  // ****************************************
  // counting, clock sources and output functions
  // ****************************************
  localparam int            CNT_W     = 10;
  localparam logic [9:0]    CNT_MAX   = 10'h3FF;
  localparam logic [2:0]    CK_SYS4   = 3'h0;
  localparam logic [2:0]    CK_SYS    = 3'h1;
  localparam logic [2:0]    CK_H16    = 3'h2;
  localparam logic [2:0]    CK_H64    = 3'h3;
  localparam logic [2:0]    CK_TBC0   = 3'h4;
  localparam logic [2:0]    CK_TBC1   = 3'h5;
  localparam logic [2:0]    CK_EXT_R  = 3'h6;
  localparam logic [2:0]    CK_EXT_F  = 3'h7;
  localparam logic [5:0]    DIV_4     = 6'h03;
  localparam logic [5:0]    DIV_16    = 6'h0F;
  localparam logic [5:0]    DIV_64    = 6'h3F;
  localparam logic [1:0]    OF_KEEP   = 2'h0;
  localparam logic [1:0]    OF_LOW    = 2'h1;
  localparam logic [1:0]    OF_HIGH   = 2'h2;
  localparam logic [1:0]    OF_TOGGLE = 2'h3;

  typedef enum logic [1:0] {
    MODE_CMP0,
    MODE_CMP1,
    MODE_PWM,
    MODE_TMR
  } mode_e;
endpackage

// ==== verilog/ctimer_if.sv ====
// tick, count, match and overflow signals shared between timer modules
`timescale 1ns/1ns
interface ctimer_if;
  import ctimer_pkg::*;
  logic             tick;
  logic [CNT_W-1:0] count;
  logic             match_a;
  logic             match_p;
  logic             overflow;
  modport src (output tick);
  modport core (input tick, output count, match_a, match_p, overflow);
  modport user (input tick, count, match_a, match_p, overflow);
endinterface

// ==== verilog/ctimer_tick.sv ====
// count clock tick generator with source select
`timescale 1ns/1ns
module ctimer_tick
  import ctimer_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // selection
  input  wire logic [2:0] clock_select,
  input  wire logic       high_clk_en,
  input  wire logic       timebase_clock,
  input  wire logic       external_count_pin,
  input  wire logic       run,
  // tick out
  ctimer_if.src           tk
);
  logic [5:0] sys_div;
  logic [5:0] h_div;
  logic       ext_prev;
  logic       tbc_prev;
  wire        ext_rise = external_count_pin & ~ext_prev;
  wire        ext_fall = ~external_count_pin & ext_prev;
  wire        tbc_rise = timebase_clock & ~tbc_prev;

  // ****************************************
  // prescalers and edge detectors
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_div  <= 6'h00;
      h_div    <= 6'h00;
      ext_prev <= 1'b0;
      tbc_prev <= 1'b0;
    end else begin
      sys_div  <= run ? sys_div + 6'h01 : 6'h00;
      h_div    <= (run && high_clk_en) ? h_div + 6'h01 : h_div;
      ext_prev <= external_count_pin;
      tbc_prev <= timebase_clock;
    end
  end

  // source select
  always_comb begin
    case (clock_select)
      CK_SYS4:  tk.tick = run && ((sys_div & DIV_4) == DIV_4);
      CK_SYS:   tk.tick = run;
      CK_H16:   tk.tick = run && high_clk_en && ((h_div & DIV_16) == DIV_16);
      CK_H64:   tk.tick = run && high_clk_en && (h_div == DIV_64);
      CK_TBC0,
      CK_TBC1:  tk.tick = run && tbc_rise;
      CK_EXT_R: tk.tick = run && ext_rise;
      CK_EXT_F: tk.tick = run && ext_fall;
      default:  tk.tick = 1'b0;
    endcase
  end
endmodule

// ==== verilog/ctimer_core.sv ====
// 10-bit counter with comparators A and P
`timescale 1ns/1ns
module ctimer_core
  import ctimer_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // control
  input  wire logic             start,
  input  wire logic             clear_on_a,
  input  wire logic [2:0]       period_bits,
  input  wire logic [CNT_W-1:0] cmp_a,
  // counter side
  ctimer_if.core                cf
);
  logic [CNT_W-1:0] count;
  wire  hit_a  = cf.tick && (count == cmp_a) && (cmp_a != 10'h000);
  // last tick of 128-count block period_bits-1; period zero wraps to overflow
  wire  [2:0] blk_next = 3'(count[9:7] + 3'h1);
  wire  hit_p  = cf.tick && (blk_next == period_bits) &&
                 (count[6:0] == 7'h7F);
  wire  ovf    = cf.tick && (count == CNT_MAX);
  wire  do_clr = clear_on_a ? hit_a : (hit_p | ovf);

  assign cf.count    = count;
  assign cf.match_a  = hit_a;
  assign cf.match_p  = hit_p && !clear_on_a;
  assign cf.overflow = ovf;

  // counter; ticks only arrive when on and not paused
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 10'h000;
    end else if (start) begin
      count <= 10'h000;
    end else if (do_clr) begin
      count <= 10'h000;
    end else if (cf.tick) begin
      count <= count + 10'h001;
    end
  end
endmodule

// ==== verilog/ctimer.sv ====
// compact timer top: registers, modes and output pin
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module ctimer
  import ctimer_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // clock sources
  input  wire logic       high_clk_en,
  input  wire logic       timebase_clock,
  input  wire logic       external_count_pin,
  // timer output
  output logic            timer_output_pin,
  output logic            match_a_flag,
  output logic            match_p_flag
);
  logic [7:0]       ctrl_a;
  logic [7:0]       ctrl_b;
  logic [7:0]       cmpa_lo;
  logic [1:0]       cmpa_hi;
  logic [7:0]       byte_buf;
  logic             on_prev;
  logic             cmp_out;
  logic             pwm_out;
  ctimer_if         bus ();

  // ****************************************
  // field decode
  // ****************************************
  wire       counter_pause        = ctrl_a[POS_PAUSE];
  wire [2:0] count_clock_select   = ctrl_a[POS_CKSEL +: 3];
  wire       counter_on           = ctrl_a[POS_ON];
  wire [2:0] period_compare_bits  = ctrl_a[POS_PERIOD +: 3];
  wire [1:0] operating_mode_field = ctrl_b[POS_MODE +: 2];
  wire [1:0] output_function_field = ctrl_b[POS_OFUNC +: 2];
  wire       output_initial_level = ctrl_b[POS_INIT];
  wire       output_invert        = ctrl_b[POS_INV];
  wire       period_duty_swap     = ctrl_b[POS_SWAP];
  wire       counter_clear_select = ctrl_b[POS_CCLR];
  wire [9:0] compare_a_value      = {cmpa_hi, cmpa_lo};
  wire       mode_pwm  = operating_mode_field == MODE_PWM;
  wire       mode_tmr  = operating_mode_field == MODE_TMR;
  wire       mode_cmp  = !mode_pwm && !mode_tmr;
  wire       start     = counter_on && !on_prev;
  wire       run       = counter_on && !counter_pause;
  // pwm: swap bit picks who clears (period); clear-select ignored
  wire       clr_on_a  = mode_pwm ? period_duty_swap
                                  : counter_clear_select;
  wire [9:0] p_value   = {period_compare_bits, 7'h00};
  wire [9:0] duty      = period_duty_swap ? p_value : compare_a_value;
  wire [10:0] period   = period_duty_swap ? {1'b0, compare_a_value} :
                         (period_compare_bits == 3'h0) ? 11'h400 :
                         {1'b0, p_value};
  wire       duty_full = {1'b0, duty} >= period;
  wire       pwm_act   = duty_full || (bus.count < duty);

  // ****************************************
  // sub-blocks
  // ****************************************
  ctimer_tick u_tick (
    .clk                (clk),
    .rstn               (rstn),
    .clock_select       (count_clock_select),
    .high_clk_en        (high_clk_en),
    .timebase_clock     (timebase_clock),
    .external_count_pin (external_count_pin),
    .run                (run),
    .tk                 (bus.src)
  );

  ctimer_core u_core (
    .clk         (clk),
    .rstn        (rstn),
    .start       (start),
    .clear_on_a  (clr_on_a),
    .period_bits (period_compare_bits),
    .cmp_a       (compare_a_value),
    .cf          (bus.core)
  );

  // ****************************************
  // register writes
  // ****************************************
  wire wr_a   = wr && addr == ADDR_CTRL_A;
  wire wr_b   = wr && addr == ADDR_CTRL_B;
  wire wr_alo = wr && addr == ADDR_CMPA_LO;
  wire wr_ahi = wr && addr == ADDR_CMPA_HI;
  wire wr_flg = wr && addr == ADDR_FLAGS;
  wire rd_chi = rd && addr == ADDR_CNT_HI;
  wire rd_ahi = rd && addr == ADDR_CMPA_HI;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a  <= CTRL_A_RESET;
      ctrl_b  <= CTRL_B_RESET;
      cmpa_lo <= 8'h00;
      cmpa_hi <= 2'h0;
      on_prev <= 1'b0;
    end else begin
      on_prev <= counter_on;
      if (wr_a) ctrl_a <= wdata;
      if (wr_b) ctrl_b <= wdata;
      if (wr_ahi) begin
        cmpa_hi <= wdata[1:0];
        cmpa_lo <= byte_buf;
      end
    end
  end

  // low-byte buffer: loaded by low writes and high-byte reads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byte_buf <= 8'h00;
    end else if (wr_alo) begin
      byte_buf <= wdata;
    end else if (rd_chi) begin
      byte_buf <= bus.count[7:0];
    end else if (rd_ahi) begin
      byte_buf <= cmpa_lo;
    end
  end

  // ****************************************
  // match flags: set wins over write-one clear
  // ****************************************
  wire set_a = bus.match_a && !mode_pwm ? 1'b1 : bus.match_a;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= set_a | (match_a_flag &
                      ~(wr_flg & wdata[POS_FLAG_A]));
      match_p_flag <= bus.match_p | (match_p_flag &
                      ~(wr_flg & wdata[POS_FLAG_P]));
    end
  end

  // ****************************************
  // compare output latch
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_out <= 1'b0;
    end else if (start && mode_cmp) begin
      cmp_out <= output_initial_level;
    end else if (bus.match_a && mode_cmp) begin
      case (output_function_field)
        OF_KEEP:   cmp_out <= cmp_out;
        OF_LOW:    cmp_out <= 1'b0;
        OF_HIGH:   cmp_out <= 1'b1;
        OF_TOGGLE: cmp_out <= ~cmp_out;
        default:   cmp_out <= cmp_out;
      endcase
    end
  end

  // pwm level before polarity
  always_comb begin
    case (output_function_field)
      OF_KEEP: pwm_out = ~output_initial_level;
      OF_LOW:  pwm_out = output_initial_level;
      OF_HIGH: pwm_out = pwm_act ? output_initial_level
                                 : ~output_initial_level;
      default: pwm_out = ~output_initial_level;
    endcase
  end

  // registered pin drive with polarity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_output_pin <= 1'b0;
    end else if (mode_tmr) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= (mode_pwm ? pwm_out : cmp_out)
                          ^ output_invert;
    end
  end

  // ****************************************
  // read data, one cycle after strobe
  // ****************************************
  logic [7:0] rmux;
  always_comb begin
    case (addr)
      ADDR_CTRL_A:  rmux = ctrl_a;
      ADDR_CTRL_B:  rmux = ctrl_b;
      ADDR_CNT_LO:  rmux = byte_buf;
      ADDR_CNT_HI:  rmux = {6'h00, bus.count[9:8]};
      ADDR_CMPA_LO: rmux = byte_buf;
      ADDR_CMPA_HI: rmux = {6'h00, cmpa_hi};
      ADDR_FLAGS:   rmux = {6'h00, match_p_flag, match_a_flag};
      default:      rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rmux : 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_start_clears: assert property (@(posedge clk) disable iff (!rstn)
    start |=> bus.count == 10'h000) else $error("start did not clear");
  a_pause_holds: assert property (@(posedge clk) disable iff (!rstn)
    (!run && !start) |=> $stable(bus.count)) else $error("count moved");
  a_p_flag_off: assert property (@(posedge clk) disable iff (!rstn)
    (clr_on_a && !mode_pwm) |-> !bus.match_p) else $error("p match");
  a_ahi_copy: assert property (@(posedge clk) disable iff (!rstn)
    wr_ahi |=> cmpa_lo == $past(byte_buf)) else $error("no copy");
  a_init_level: assert property (@(posedge clk) disable iff (!rstn)
    (start && mode_cmp) |=> ##1 timer_output_pin ==
    ($past(output_initial_level,2) ^ $past(output_invert,2)))
    else $error("initial level");
  a_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    bus.match_a |=> match_a_flag) else $error("flag lost");
  a_p_clear: assert property (@(posedge clk) disable iff (!rstn)
    bus.match_p |=> bus.count == 10'h000) else $error("p no clear");
  a_tmr_pin: assert property (@(posedge clk) disable iff (!rstn)
    mode_tmr |=> !timer_output_pin) else $error("pin in timer mode");
endmodule

// ==== testbench/ctimer_tb_top.sv ====
// self-checking bench for the compact timer
`timescale 1ns/1ns
module ctimer_tb_top;
  import ctimer_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  logic       clk, rstn, wr, rd, high_clk_en;
  logic       timebase_clock, external_count_pin;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic       timer_output_pin, match_a_flag, match_p_flag;
  int         n_fail, n_compared;
  logic [7:0] d;
  logic [9:0] c1, c2;
  int         n;

  ctimer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .high_clk_en(high_clk_en),
    .timebase_clock(timebase_clock),
    .external_count_pin(external_count_pin),
    .timer_output_pin(timer_output_pin), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag));

  // clock generator
  always #5 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task final_report;
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // high byte first so the low byte is latched with it
  task automatic rcount(output logic [9:0] v);
    logic [7:0] h, l;
    rreg(ADDR_CNT_HI, h);
    rreg(ADDR_CNT_LO, l);
    v = {h[1:0], l};
  endtask

  task automatic set_a(input logic [9:0] v);
    wreg(ADDR_CMPA_LO, v[7:0]);
    wreg(ADDR_CMPA_HI, {6'h00, v[9:8]});
  endtask

  // stop first, clear flags, then set mode and start
  task automatic run(input logic [7:0] b, input logic [7:0] a);
    wreg(ADDR_CTRL_A, 8'h00);
    wreg(ADDR_FLAGS, 8'h03);
    wreg(ADDR_CTRL_B, b);
    wreg(ADDR_CTRL_A, a);
  endtask

  task automatic wait_flag(input logic on_a, input int lim, output int k);
    k = 0;
    while ((on_a ? match_a_flag : match_p_flag) !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (k >= lim) begin
      n_fail++;
      $display("[FAIL] %0t flag wait timed out", $time);
      final_report();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      rreg(i[2:0], d);
      chk(d === 8'h00, "reset or unmapped value not zero");
    end
    wreg(ADDR_CNT_LO, 8'h55);
    rcount(c1);
    chk(c1 === 10'h000, "count bytes writable");
    wreg(ADDR_CMPA_LO, 8'h34);
    rreg(ADDR_CMPA_HI, d);
    rreg(ADDR_CMPA_LO, d);
    chk(d === 8'h00, "low byte not held in buffer");
    wreg(ADDR_CMPA_LO, 8'h34);
    wreg(ADDR_CMPA_HI, 8'hFF);
    rreg(ADDR_CMPA_HI, d);
    chk(d === 8'h03, "compare high byte wrong");
    rreg(ADDR_CMPA_LO, d);
    chk(d === 8'h34, "low byte not copied on high write");
  endtask

  task automatic cmp_case(input logic [7:0] b, input logic s, input logic f);
    set_a(10'h100);
    run(b, 8'h19);
    repeat (3) @(negedge clk);
    chk(timer_output_pin === s, "start level wrong");
    wait_flag(1'b1, 400, n);
    chk(n >= 250 && n <= 262, "A match time wrong");
    chk(match_p_flag === 1'b0, "P flag with clear on A");
    repeat (3) @(negedge clk);
    chk(timer_output_pin === f, "pin after A match wrong");
    rcount(c1);
    chk(c1 < 10'h020, "counter not cleared by A");
  endtask

  task automatic t_pmatch;
    set_a(10'h3FF);
    run(8'h30, 8'h19);
    wait_flag(1'b0, 300, n);
    chk(n >= 124 && n <= 132, "P match period wrong");
    repeat (140) @(negedge clk);
    chk(timer_output_pin === 1'b0, "P match moved the pin");
    chk(match_a_flag === 1'b0, "A flag without A match");
    run(8'h30, 8'h18);
    wait_flag(1'b0, 1200, n);
    chk(n >= 1018 && n <= 1030, "overflow period wrong");
    set_a(10'h010);
    run(8'h30, 8'h19);
    wait_flag(1'b0, 300, n);
    chk(match_a_flag === 1'b1, "A flag missing");
    set_a(10'h000);
    run(8'h31, 8'h18);
    repeat (1100) @(negedge clk);
    chk(match_a_flag === 1'b0, "A flag at zero value");
    rcount(c1);
    chk(c1 < 10'h080, "no overflow at maximum");
  endtask

  task automatic t_hold;
    run(8'hCC, 8'h18);
    repeat (50) @(negedge clk);
    wreg(ADDR_CTRL_A, 8'h98);
    rcount(c1);
    repeat (20) @(negedge clk);
    rcount(c2);
    chk(c1 === c2 && c1 > 10'd40, "pause did not freeze");
    wreg(ADDR_CTRL_A, 8'h18);
    repeat (20) @(negedge clk);
    rcount(c1);
    chk(c1 > c2 && c1 < c2 + 10'd40, "resume not from held value");
    chk(timer_output_pin === 1'b0, "pin used in timer mode");
    wreg(ADDR_CTRL_A, 8'h10);
    rcount(c1);
    repeat (20) @(negedge clk);
    rcount(c2);
    chk(c1 === c2, "counter moved while off");
    wreg(ADDR_CTRL_A, 8'h18);
    rcount(c1);
    chk(c1 < 10'd8, "start did not clear counter");
  endtask

  task automatic t_clksel;
    int exp [8] = '{100, 400, 25, 6, 20, 20, 20, 20};
    for (int s = 0; s < 8; s++) begin
      run(8'hC0, {1'b0, s[2:0], 4'h8});
      for (int k = 0; k < 400; k++) begin
        @(posedge clk);
        if (k % 10 == 9) begin
          external_count_pin <= ~external_count_pin;
          timebase_clock <= ~timebase_clock;
        end
      end
      wreg(ADDR_CTRL_A, {1'b0, s[2:0], 4'h0});
      rcount(c1);
      chk(c1 + 3 >= exp[s] && c1 <= exp[s] + 3, "count rate wrong");
    end
  endtask

  task automatic pwm_case(input logic [9:0] a, input logic [7:0] b,
                          input int e);
    int ones;
    ones = 0;
    set_a(a);
    run(b, 8'h19);
    repeat (10) @(negedge clk);
    repeat (512) begin
      @(negedge clk);
      if (timer_output_pin === 1'b1) ones++;
    end
    chk(ones + 6 >= e && ones <= e + 6, "pwm high time wrong");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 0; rstn = 0; wr = 0; rd = 0; addr = 3'h0; wdata = 8'h00;
    high_clk_en = 1; timebase_clock = 0; external_count_pin = 0;
    n_fail = 0; n_compared = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(timer_output_pin === 1'b0 && match_a_flag === 1'b0, "reset outputs");
    t_regs();
    cmp_case(8'h31, 1'b0, 1'b1);
    cmp_case(8'h51, 1'b0, 1'b0);
    cmp_case(8'h19, 1'b1, 1'b0);
    cmp_case(8'h65, 1'b1, 1'b0);
    cmp_case(8'h21, 1'b0, 1'b1);
    cmp_case(8'h09, 1'b1, 1'b1);
    t_pmatch();
    t_hold();
    t_clksel();
    pwm_case(10'd32, 8'hA9, 128);
    pwm_case(10'd32, 8'hAD, 384);
    pwm_case(10'd32, 8'hA1, 384);
    pwm_case(10'd32, 8'h99, 512);
    pwm_case(10'd32, 8'h89, 0);
    pwm_case(10'd200, 8'hA8, 512);
    pwm_case(10'd256, 8'hAA, 256);
    final_report();
  end
endmodule
